//--- relay_ladder_bit_logic_unit.sv
// bit logic execution unit: evaluates ladder instructions per scan
// Function
// - open begin loads addressed bit
// - closed begin loads inverted bit
// - coil writes result to relay bit
// - invert complements the result
// - series contacts AND bit or complement
// - parallel contacts OR bit or complement
// - edge begin true one scan on edge
// - edge series ANDs one-scan edge term
// - edge parallel ORs one-scan edge term
// - rising pulse coil on one scan
// - falling pulse coil on one scan
// - toggle coil flips on result rise
// - series join ANDs with stacked block
// - parallel join ORs with stacked block
// - step size one, two for high addresses; edge forms and pulse coils two, toggle three
module relay_ladder_bit_logic_unit
	import rlu_pkg::*;
#(
	parameter int unsigned EDGE_SLOTS  = 16,
	parameter int unsigned STACK_DEPTH = 8
)(
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          instr_valid,
	input  wire logic [4:0]                    instr_op,
	input  wire logic [2:0]                    instr_class,
	input  wire logic [ADDR_W-1:0]             instr_addr,
	input  wire logic [$clog2(EDGE_SLOTS)-1:0] instr_slot,
	input  wire logic                          bit_value,
	input  wire logic                          first_scan,
	output logic                               result_reg,
	output logic                               wr_en_reg,
	output logic [2:0]                         wr_class_reg,
	output logic [ADDR_W-1:0]                  wr_addr_reg,
	output logic                               wr_value_reg,
	output logic [1:0]                         steps_reg,
	output logic                               stack_err_reg
);

	localparam int unsigned SW = $clog2(EDGE_SLOTS);
	localparam int unsigned PW = $clog2(STACK_DEPTH + 1);

	logic                 prev_mem [EDGE_SLOTS];
	logic [STACK_DEPTH-1:0] stack_reg;
	logic [PW-1:0]        sp_reg;
	logic                 in_rung_reg;
	logic                 result_next;
	logic                 cur_sig;
	logic                 prev_sig;
	logic                 rise;
	logic                 fall;
	logic                 is_begin;
	logic                 is_join;
	logic                 top_bit;
	opcode_e              op;

	assign op = opcode_e'(instr_op);

	// true when the instruction starts a new logic operation
	function automatic logic op_is_begin(input opcode_e o);
		return o == op_begin_open_contact || o == op_begin_closed_contact ||
			o == op_begin_rising_edge || o == op_begin_falling_edge;
	endfunction : op_is_begin

	// step count for a given instruction and operand
	function automatic logic [1:0] step_size(input opcode_e o, input logic [2:0] c,
		input logic [ADDR_W-1:0] a);
		logic lng;
		lng = 1'b0;
		unique case (relay_class_e'(c))
			cls_input, cls_output, cls_link: lng = (a >= IO_LONG_LIM);
			cls_internal, cls_alarm:         lng = (a >= INT_LONG_LIM);
			cls_timer, cls_counter:          lng = (a >= TC_LONG_LIM);
			default:                         lng = 1'b0;
		endcase
		unique case (o)
			op_begin_open_contact, op_begin_closed_contact, op_drive_coil,
			op_series_open_contact, op_series_closed_contact,
			op_par_open_contact, op_par_closed_contact:
				return lng ? STEPS_LONG : STEPS_SHORT;
			op_begin_rising_edge, op_begin_falling_edge, op_series_rising_edge,
			op_series_falling_edge, op_par_rising_edge, op_par_falling_edge,
			op_pulse_coil_rising, op_pulse_coil_falling:
				return STEPS_EDGE;
			op_toggle_coil:
				return STEPS_TOGGLE;
			default:
				return STEPS_SHORT;
		endcase
	endfunction : step_size

	// edge trigger source: operand bit for contacts, result for coils
	always_comb
	begin
		is_begin = op_is_begin(op);
		is_join  = (op == op_series_block_join) || (op == op_parallel_block_join);
		top_bit  = (sp_reg != '0) ? stack_reg[0] : 1'b0;
		cur_sig  = (op == op_pulse_coil_rising || op == op_pulse_coil_falling ||
			op == op_toggle_coil) ? result_reg : bit_value;
		prev_sig = prev_mem[instr_slot];
		rise     = cur_sig & ~prev_sig;
		fall     = ~cur_sig & prev_sig;
	end

	// next operation result
	always_comb
	begin
		result_next = result_reg;
		unique case (op)
			op_begin_open_contact:    result_next = bit_value;
			op_begin_closed_contact:  result_next = ~bit_value;
			op_invert:                result_next = ~result_reg;
			op_series_open_contact:   result_next = result_reg & bit_value;
			op_series_closed_contact: result_next = result_reg & ~bit_value;
			op_par_open_contact:      result_next = result_reg | bit_value;
			op_par_closed_contact:    result_next = result_reg | ~bit_value;
			op_begin_rising_edge:     result_next = rise;
			op_begin_falling_edge:    result_next = fall;
			op_series_rising_edge:    result_next = result_reg & rise;
			op_series_falling_edge:   result_next = result_reg & fall;
			op_par_rising_edge:       result_next = result_reg | rise;
			op_par_falling_edge:      result_next = result_reg | fall;
			op_series_block_join:     result_next = result_reg & top_bit;
			op_parallel_block_join:   result_next = result_reg | top_bit;
			default:                  result_next = result_reg;
		endcase
	end

	// operation result register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			result_reg <= 1'b0;
		else if (instr_valid)
			result_reg <= result_next;
	end

	// rung tracking: a begin inside a rung nests a block
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			in_rung_reg <= 1'b0;
		else if (instr_valid)
		begin
			if (is_begin)
				in_rung_reg <= 1'b1;
			else if (op == op_end_scan)
				in_rung_reg <= 1'b0;
		end
	end

	// block stack, top at bit 0
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stack_reg     <= '0;
			sp_reg        <= '0;
			stack_err_reg <= 1'b0;
		end
		else if (instr_valid)
		begin
			if (op == op_end_scan)
			begin
				stack_reg <= '0;
				sp_reg    <= '0;
			end
			else if (is_begin && in_rung_reg)
			begin
				stack_reg <= {stack_reg[STACK_DEPTH-2:0], result_reg};
				if (sp_reg == PW'(STACK_DEPTH))
					stack_err_reg <= 1'b1;
				else
					sp_reg <= sp_reg + PW'(1);
			end
			else if (is_join)
			begin
				stack_reg <= {1'b0, stack_reg[STACK_DEPTH-1:1]};
				if (sp_reg == '0)
					stack_err_reg <= 1'b1;
				else
					sp_reg <= sp_reg - PW'(1);
			end
		end
	end

	// per-instance previous trigger values
	generate
		for (genvar g = 0; g < EDGE_SLOTS; g++)
		begin : g_edge
			always_ff @(posedge clk)
			begin
				if (sys_rst)
					prev_mem[g] <= 1'b0;
				else if (instr_valid && instr_slot == SW'(g) && step_size(op, 3'h0, '0)
					== STEPS_EDGE | op == op_toggle_coil)
					prev_mem[g] <= first_scan ? cur_sig : cur_sig;
			end
		end
	endgenerate

	// relay write port for coils
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wr_en_reg    <= 1'b0;
			wr_class_reg <= '0;
			wr_addr_reg  <= '0;
			wr_value_reg <= 1'b0;
		end
		else
		begin
			wr_class_reg <= instr_class;
			wr_addr_reg  <= instr_addr;
			wr_en_reg    <= 1'b0;
			wr_value_reg <= 1'b0;
			if (instr_valid)
			begin
				unique case (op)
					op_drive_coil:
					begin
						wr_en_reg    <= 1'b1;
						wr_value_reg <= result_reg;
					end
					op_pulse_coil_rising:
					begin
						wr_en_reg    <= 1'b1;
						wr_value_reg <= rise;
					end
					op_pulse_coil_falling:
					begin
						wr_en_reg    <= 1'b1;
						wr_value_reg <= fall;
					end
					op_toggle_coil:
					begin
						wr_en_reg    <= rise;
						wr_value_reg <= ~bit_value;
					end
					default:
						wr_en_reg <= 1'b0;
				endcase
			end
		end
	end

	// step count of the current instruction
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			steps_reg <= STEPS_SHORT;
		else if (instr_valid)
			steps_reg <= step_size(op, instr_class, instr_addr);
	end

endmodule : relay_ladder_bit_logic_unit

//--- relay_mem.sv
// behavioural relay bit memory facing the bit logic unit
module relay_mem
(
	input  wire logic        clk,
	input  wire logic [2:0]  rd_class,
	input  wire logic [15:0] rd_addr,
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_class,
	input  wire logic [15:0] wr_addr,
	input  wire logic        wr_value,
	output logic             rd_value
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mem [8][16];
	// bit read by class and low address bits
	assign rd_value = mem[rd_class][rd_addr[3:0]];
	// coil writes land at the clock edge
	always @(posedge clk)
		if (wr_en)
			mem[wr_class][wr_addr[3:0]] <= wr_value;
endmodule : relay_mem

//--- rlu_checker_sva.sv
// port checker of the bit logic unit, bound to its top module
module rlu_checker
	import rlu_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              instr_valid,
	input wire logic [4:0]        instr_op,
	input wire logic [2:0]        instr_class,
	input wire logic [ADDR_W-1:0] instr_addr,
	input wire logic              bit_value,
	input wire logic              result_reg,
	input wire logic              wr_en_reg,
	input wire logic              wr_value_reg,
	input wire logic [1:0]        steps_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// one valid instruction of a given opcode
	sequence op_s(logic [4:0] o);
		instr_valid && instr_op == o;
	endsequence
	open_begin_a: assert property
		(op_s(op_begin_open_contact) |=> result_reg == $past(bit_value))
		else $error("open begin result wrong");
	closed_begin_a: assert property
		(op_s(op_begin_closed_contact) |=> result_reg != $past(bit_value))
		else $error("closed begin result wrong");
	coil_write_a: assert property
		(op_s(op_drive_coil) |=> wr_en_reg && wr_value_reg == $past(result_reg))
		else $error("coil write wrong");
	invert_flip_a: assert property
		(op_s(op_invert) |=> result_reg != $past(result_reg))
		else $error("invert wrong");
	series_closed_a: assert property
		(op_s(op_series_closed_contact) |=> result_reg == ($past(result_reg) && !$past(bit_value)))
		else $error("series closed wrong");
	par_closed_a: assert property
		(op_s(op_par_closed_contact) |=> result_reg == ($past(result_reg) || !$past(bit_value)))
		else $error("parallel closed wrong");
	fall_quiet_a: assert property
		(op_s(op_series_falling_edge) ##0 bit_value |=> !result_reg)
		else $error("falling term on high bit");
	toggle_inv_a: assert property
		(op_s(op_toggle_coil) |=> !wr_en_reg || wr_value_reg != $past(bit_value))
		else $error("toggle value wrong");
	long_steps_a: assert property
		(op_s(op_begin_closed_contact) ##0 instr_class == cls_input && instr_addr >= IO_LONG_LIM
		|=> steps_reg == STEPS_LONG)
		else $error("long step size wrong");
endmodule : rlu_checker

bind relay_ladder_bit_logic_unit rlu_checker i_chk (.clk, .sys_rst, .instr_valid, .instr_op,
	.instr_class, .instr_addr, .bit_value, .result_reg, .wr_en_reg, .wr_value_reg, .steps_reg);

//--- rlu_pkg.sv
// package of opcodes, relay classes and step-size limits for the bit logic unit
package rlu_pkg;

	// instruction opcodes
	typedef enum logic [4:0] {
		op_nop                 = 5'h00,
		op_begin_open_contact  = 5'h01,
		op_begin_closed_contact= 5'h02,
		op_drive_coil          = 5'h03,
		op_invert              = 5'h04,
		op_series_open_contact = 5'h05,
		op_series_closed_contact = 5'h06,
		op_par_open_contact    = 5'h07,
		op_par_closed_contact  = 5'h08,
		op_begin_rising_edge   = 5'h09,
		op_begin_falling_edge  = 5'h0a,
		op_series_rising_edge  = 5'h0b,
		op_series_falling_edge = 5'h0c,
		op_par_rising_edge     = 5'h0d,
		op_par_falling_edge    = 5'h0e,
		op_pulse_coil_rising   = 5'h0f,
		op_pulse_coil_falling  = 5'h10,
		op_toggle_coil         = 5'h11,
		op_series_block_join   = 5'h12,
		op_parallel_block_join = 5'h13,
		op_end_scan            = 5'h14
	} opcode_e;

	// relay classes of the addressed bit
	typedef enum logic [2:0] {
		cls_input    = 3'h0,
		cls_output   = 3'h1,
		cls_internal = 3'h2,
		cls_timer    = 3'h3,
		cls_counter  = 3'h4,
		cls_link     = 3'h5,
		cls_pulse    = 3'h6,
		cls_alarm    = 3'h7
	} relay_class_e;

	localparam int unsigned ADDR_W        = 16;
	localparam logic [15:0] IO_LONG_LIM   = 16'h0500; // relay 1280
	localparam logic [15:0] INT_LONG_LIM  = 16'h0460; // relay 1120
	localparam logic [15:0] TC_LONG_LIM   = 16'h0100; // contact 256
	localparam logic [1:0]  STEPS_SHORT   = 2'h1;
	localparam logic [1:0]  STEPS_LONG    = 2'h2;
	localparam logic [1:0]  STEPS_EDGE    = 2'h2;
	localparam logic [1:0]  STEPS_TOGGLE  = 2'h3;

endpackage : rlu_pkg

//--- tb_top.sv
// self-checking testbench of the bit logic unit with a relay memory model
module tb_top import rlu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        sys_rst;
	logic        instr_valid;
	logic [4:0]  instr_op;
	logic [2:0]  instr_class;
	logic [15:0] instr_addr;
	logic [3:0]  instr_slot;
	logic        bit_value;
	logic        result_reg;
	logic        wr_en_reg;
	logic [2:0]  wr_class_reg;
	logic [15:0] wr_addr_reg;
	logic        wr_value_reg;
	logic [1:0]  steps_reg;
	logic        stack_err_reg;
	int          fail_count = 0;
	int          cmp_count = 0;
	relay_ladder_bit_logic_unit i_dut (.clk, .sys_rst, .instr_valid, .instr_op, .instr_class,
		.instr_addr, .instr_slot, .bit_value, .first_scan(1'b0), .result_reg, .wr_en_reg,
		.wr_class_reg, .wr_addr_reg, .wr_value_reg, .steps_reg, .stack_err_reg);
	relay_mem i_mem (.clk, .rd_class(instr_class), .rd_addr(instr_addr), .wr_en(wr_en_reg),
		.wr_class(wr_class_reg), .wr_addr(wr_addr_reg), .wr_value(wr_value_reg), .rd_value(bit_value));
	// count a compare and report a difference
	task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %b expected %b", $time, seen, exp);
		end
	endtask : chk
	// preset operand bit (v[1] keeps it), issue one instruction, judge result or coil write
	task automatic row(input opcode_e op, input logic [2:0] c, input logic [15:0] a,
		input logic [1:0] v, input logic [3:0] s, input logic [1:0] e);
		if (!v[1])
			i_mem.mem[c][a[3:0]] = v[0];
		@(posedge clk);
		instr_op    <= op;
		instr_class <= c;
		instr_addr  <= a;
		instr_slot  <= s;
		instr_valid <= 1'b1;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		if (op inside {op_drive_coil, op_pulse_coil_rising, op_pulse_coil_falling, op_toggle_coil})
			chk({wr_en_reg, wr_value_reg & wr_en_reg}, e);
		else
			chk({1'b0, result_reg}, e);
	endtask : row
	// contacts, inversion, block joins and coil
	task automatic t_logic();
		row(op_begin_open_contact, 3'h0, 16'h0, 2'h1, 4'h0, 2'h1);
		row(op_series_closed_contact, 3'h0, 16'h4ff, 2'h0, 4'h0, 2'h1);
		chk(steps_reg, STEPS_SHORT);
		row(op_begin_closed_contact, 3'h0, 16'h500, 2'h1, 4'h0, 2'h0);
		chk(steps_reg, STEPS_LONG);
		row(op_parallel_block_join, 3'h0, 16'h0, 2'h2, 4'h0, 2'h1);
		row(op_invert, 3'h0, 16'h0, 2'h2, 4'h0, 2'h0);
		row(op_par_closed_contact, 3'h2, 16'h460, 2'h0, 4'h0, 2'h1);
		chk(steps_reg, STEPS_LONG);
		row(op_begin_open_contact, 3'h4, 16'hff, 2'h0, 4'h0, 2'h0);
		chk(steps_reg, STEPS_SHORT);
		row(op_series_block_join, 3'h0, 16'h0, 2'h2, 4'h0, 2'h0);
		row(op_drive_coil, 3'h1, 16'h3, 2'h2, 4'h0, 2'h2);
	endtask : t_logic
	// edge contacts with separate slot memories
	task automatic t_edge();
		row(op_begin_rising_edge, 3'h0, 16'h0, 2'h1, 4'h0, 2'h1);
		row(op_begin_rising_edge, 3'h0, 16'h0, 2'h1, 4'h0, 2'h0);
		row(op_begin_rising_edge, 3'h0, 16'h0, 2'h1, 4'h1, 2'h1);
		row(op_begin_falling_edge, 3'h0, 16'h0, 2'h0, 4'h0, 2'h1);
		row(op_series_falling_edge, 3'h0, 16'h0, 2'h1, 4'h3, 2'h0);
		row(op_par_rising_edge, 3'h0, 16'h0, 2'h1, 4'h2, 2'h1);
	endtask : t_edge
	// pulse coils and toggle output
	task automatic t_coil();
		row(op_pulse_coil_rising, 3'h6, 16'h0, 2'h2, 4'h4, 2'h3);
		row(op_pulse_coil_rising, 3'h6, 16'h0, 2'h2, 4'h4, 2'h2);
		row(op_toggle_coil, 3'h1, 16'h2, 2'h0, 4'h6, 2'h3);
		row(op_toggle_coil, 3'h1, 16'h2, 2'h2, 4'h6, 2'h0);
		row(op_invert, 3'h0, 16'h0, 2'h2, 4'h0, 2'h0);
		row(op_pulse_coil_falling, 3'h6, 16'h0, 2'h2, 4'h4, 2'h3);
	endtask : t_coil
	// open contacts, remaining edge forms and a long timer operand
	task automatic t_open();
		row(op_begin_open_contact, 3'h3, 16'h100, 2'h1, 4'h0, 2'h1);
		chk(steps_reg, STEPS_LONG);
		row(op_series_open_contact, 3'h5, 16'h4, 2'h0, 4'h0, 2'h0);
		row(op_par_open_contact, 3'h5, 16'h5, 2'h1, 4'h0, 2'h1);
		row(op_series_rising_edge, 3'h0, 16'h7, 2'h1, 4'h7, 2'h1);
		row(op_series_rising_edge, 3'h0, 16'h7, 2'h2, 4'h7, 2'h0);
		row(op_par_falling_edge, 3'h0, 16'h7, 2'h0, 4'h7, 2'h1);
	endtask : t_open
	// scan end, join on an empty stack, error flag and a mid-run reset
	task automatic t_stack();
		chk({1'b0, stack_err_reg}, 2'h0);
		row(op_end_scan, 3'h0, 16'h0, 2'h2, 4'h0, 2'h1);
		row(op_begin_open_contact, 3'h0, 16'h1, 2'h1, 4'h0, 2'h1);
		row(op_series_block_join, 3'h0, 16'h0, 2'h2, 4'h0, 2'h0);
		chk({1'b0, stack_err_reg}, 2'h1);
		row(op_invert, 3'h0, 16'h0, 2'h2, 4'h0, 2'h1);
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk({1'b0, stack_err_reg}, 2'h0);
		row(op_begin_rising_edge, 3'h0, 16'h0, 2'h1, 4'h1, 2'h1);
	endtask : t_stack
	// print counts and verdict, then stop
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// watchdog against a hang
	initial
	begin
		#20000;
		fail_count++;
		results();
	end
	// reset then scenarios
	initial
	begin
		sys_rst     = 1'b1;
		instr_valid = 1'b0;
		instr_op    = 5'h00;
		instr_class = 3'h0;
		instr_addr  = 16'h0;
		instr_slot  = 4'h0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_logic();
		t_edge();
		t_coil();
		t_open();
		t_stack();
		results();
	end
endmodule : tb_top
